// ==== verilog/pcg_pkg.sv ====
// What this block does
// - Bit 5 of routing A routes the unclocked comparator output to a pin.
// - Bit 4 of routing A routes the clocked comparator output to a pin.
// - Bit 3 of routing A drives the inverted system clock onto a pin.
// - Bit 2 of routing A routes both SMBus data and clock to pins.
// - Bit 1 of routing A routes SPI: three pins, four with slave select.
// - Bit 0 of routing A ties UART transmit and receive to port 0 pins 4, 5.
// - Unused routing bits read zero and ignore writes.
// - Bit 7 of routing B disables all weak pullups.
// - Bit 6 of routing B enables the crossbar; clear means no routing.
// - Bits 5 and 4 of routing B route timer 1 and timer 0 inputs.
// - Bit 3 of routing B routes the counter array count input.
// - Two-bit module field routes none, one, two or three array modules.
// - Writing a port data register stores the value in the port latch.
// - A plain port read returns the pin level, even for peripheral pins.
// - Read-modify-write reads return the latch, not the pin.
// - A port bit set as analog input reads zero on a plain read.
// - Open-drain latch one leaves the pin floating, zero drives it low.
// - Input-mode zero makes a pin analog: no pullup, driver or receiver.
// - Output-mode one is push-pull, zero open-drain; ignored for analog pins.
// - SMBus pins are always open-drain whatever the output mode.
// - A skip bit of one makes the crossbar pass over that pin.
// - Each enabled peripheral except UART takes the lowest free unskipped pin in order.
// - With the crossbar disabled all port output drivers are off.
// - Weak pullups act only on open-drain pins not driving low.
`default_nettype none
package pcg_pkg;
    // ************************************
    // Register addresses
    // ************************************
    localparam logic [7:0] ADDR_PORT0_LATCH   = 8'h80;
    localparam logic [7:0] ADDR_PORT1_LATCH   = 8'h90;
    localparam logic [7:0] ADDR_PORT0_DRIVE   = 8'hA4;
    localparam logic [7:0] ADDR_PORT1_DRIVE   = 8'hA5;
    localparam logic [7:0] ADDR_PORT0_BYPASS  = 8'hD4;
    localparam logic [7:0] ADDR_PORT1_BYPASS  = 8'hD5;
    localparam logic [7:0] ADDR_ROUTING_A     = 8'hE1;
    localparam logic [7:0] ADDR_ROUTING_B     = 8'hE2;
    localparam logic [7:0] ADDR_PORT0_ANADIG  = 8'hF1;
    localparam logic [7:0] ADDR_PORT1_ANADIG  = 8'hF2;
    // ************************************
    // Reset values and writable masks
    // ************************************
    localparam logic [7:0] RST_LATCH     = 8'hFF;
    localparam logic [7:0] RST_ANADIG    = 8'hFF;
    localparam logic [7:0] RST_ZERO      = 8'h00;
    localparam logic [7:0] MASK_ROUTING_A = 8'h3F;
    localparam logic [7:0] MASK_ROUTING_B = 8'hFB;
    localparam logic [7:0] MASK_BYPASS1  = 8'h7F;
    // ************************************
    // Field positions
    // ************************************
    localparam int RA_UART = 0;
    localparam int RA_SPI  = 1;
    localparam int RA_SMB  = 2;
    localparam int RA_SYSC = 3;
    localparam int RA_CMPS = 4;
    localparam int RA_CMPA = 5;
    localparam int RB_ARRM = 0;
    localparam int RB_CNT  = 3;
    localparam int RB_TMR0 = 4;
    localparam int RB_TMR1 = 5;
    localparam int RB_XBAR = 6;
    localparam int RB_PUD  = 7;
    // ************************************
    // Crossbar signal indices
    // ************************************
    localparam int NPIN = 16;
    localparam int NSIG = 15;
    localparam int SG_SCK  = 0;
    localparam int SG_MISO = 1;
    localparam int SG_MOSI = 2;
    localparam int SG_SSEL = 3;
    localparam int SG_SDA  = 4;
    localparam int SG_SCL  = 5;
    localparam int SG_CMPS = 6;
    localparam int SG_CMPA = 7;
    localparam int SG_SYSC = 8;
    localparam int SG_ARR0 = 9;
    localparam int SG_ARR1 = 10;
    localparam int SG_ARR2 = 11;
    localparam int SG_CNT  = 12;
    localparam int SG_TMR0 = 13;
    localparam int SG_TMR1 = 14;
    localparam int UART_TX_PIN = 4;
    localparam int UART_RX_PIN = 5;
    localparam logic [15:0] UART_PIN_MASK = 16'h0030;
    // Priority slot k holds a signal index, slot 0 highest
    localparam logic [59:0] PRIO_DEFAULT = 60'hEDC_BA98_7654_3210;
endpackage
`default_nettype wire

// ==== verilog/pcg_pin_cell.sv ====
`timescale 1ns/1ps
`default_nettype none
// ************************************
// One pin driver cell, registered
// ************************************
module pcg_pin_cell (
    input  wire logic core_clk,     // Core clock
    input  wire logic rst,          // Async reset
    input  wire logic xbar_en,      // Crossbar enable
    input  wire logic digital,      // Pin is digital
    input  wire logic push_pull,    // Output mode select
    input  wire logic force_od,     // SMBus forces open-drain
    input  wire logic drive_req,    // Source wants to drive
    input  wire logic value,        // Level to drive
    input  wire logic pud,          // Pullups disabled
    output logic      pin_out,      // Output level
    output logic      pin_oe,       // Output enable
    output logic      pin_pullup    // Weak pullup on
);
    wire pp     = push_pull & ~force_od;
    // Analog pins or a stopped crossbar never drive
    wire next_oe = xbar_en & digital & drive_req & (pp | ~value);
    // Pullup off when driving low, to save power
    wire next_pu = ~pud & digital & ~pp & ~(next_oe & ~value);

    // Output flops
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            pin_out    <= 1'b1;
            pin_oe     <= 1'b0;
            pin_pullup <= 1'b0;
        end else begin
            pin_out    <= value;
            pin_oe     <= next_oe;
            pin_pullup <= next_pu;
        end
    end
endmodule // pcg_pin_cell
`default_nettype wire

// ==== verilog/pcg_crossbar.sv ====
`timescale 1ns/1ps
`default_nettype none
module pcg_crossbar #(
    parameter logic [59:0] PRIO = pcg_pkg::PRIO_DEFAULT    // Priority order
) (
    input  wire logic        core_clk,       // Core clock
    input  wire logic        rst,            // Async reset
    input  wire logic [7:0]  sfr_addr,       // Register address
    input  wire logic        sfr_wr,         // Write strobe
    input  wire logic [7:0]  sfr_wdata,      // Write data
    input  wire logic        sfr_rd,         // Read strobe
    input  wire logic        sfr_rmw,        // Read is read-modify-write
    output logic      [7:0]  sfr_rdata,      // Read data
    input  wire logic [15:0] pin_in,         // Pin levels
    output logic      [15:0] pin_out,        // Pin drive levels
    output logic      [15:0] pin_oe,         // Pin output enables
    output logic      [15:0] pin_pullup,     // Weak pullup enables
    input  wire logic [14:0] periph_out,     // Peripheral levels
    input  wire logic [14:0] periph_oe,      // Peripheral drive requests
    output logic      [14:0] periph_in,      // Pin levels to peripherals
    input  wire logic        spi_four_wire,  // SPI uses slave select
    input  wire logic        uart_transmit_out, // UART transmit
    output logic             uart_receive_in    // UART receive
);
    import pcg_pkg::*;

    // ************************************
    // Register file
    // ************************************
    logic [7:0] port0_data_latch;
    logic [7:0] port1_data_latch;
    logic [7:0] port0_drive_select;
    logic [7:0] port1_drive_select;
    logic [7:0] port0_crossbar_bypass;
    logic [7:0] port1_crossbar_bypass;
    logic [7:0] peripheral_routing_a;
    logic [7:0] peripheral_routing_b;
    logic [7:0] port0_analog_digital_select;
    logic [7:0] port1_analog_digital_select;

    // Address decode
    wire wr_l0 = sfr_wr & (sfr_addr == ADDR_PORT0_LATCH);
    wire wr_l1 = sfr_wr & (sfr_addr == ADDR_PORT1_LATCH);
    wire wr_d0 = sfr_wr & (sfr_addr == ADDR_PORT0_DRIVE);
    wire wr_d1 = sfr_wr & (sfr_addr == ADDR_PORT1_DRIVE);
    wire wr_b0 = sfr_wr & (sfr_addr == ADDR_PORT0_BYPASS);
    wire wr_b1 = sfr_wr & (sfr_addr == ADDR_PORT1_BYPASS);
    wire wr_ra = sfr_wr & (sfr_addr == ADDR_ROUTING_A);
    wire wr_rb = sfr_wr & (sfr_addr == ADDR_ROUTING_B);
    wire wr_a0 = sfr_wr & (sfr_addr == ADDR_PORT0_ANADIG);
    wire wr_a1 = sfr_wr & (sfr_addr == ADDR_PORT1_ANADIG);

    // Register writes; unused bits masked so they stay zero
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            port0_data_latch            <= RST_LATCH;
            port1_data_latch            <= RST_LATCH;
            port0_drive_select          <= RST_ZERO;
            port1_drive_select          <= RST_ZERO;
            port0_crossbar_bypass       <= RST_ZERO;
            port1_crossbar_bypass       <= RST_ZERO;
            peripheral_routing_a        <= RST_ZERO;
            peripheral_routing_b        <= RST_ZERO;
            port0_analog_digital_select <= RST_ANADIG;
            port1_analog_digital_select <= RST_ANADIG;
        end else begin
            if (wr_l0) port0_data_latch <= sfr_wdata;
            if (wr_l1) port1_data_latch <= sfr_wdata;
            if (wr_d0) port0_drive_select <= sfr_wdata;
            if (wr_d1) port1_drive_select <= sfr_wdata;
            if (wr_b0) port0_crossbar_bypass <= sfr_wdata;
            if (wr_b1) port1_crossbar_bypass <= sfr_wdata & MASK_BYPASS1;
            if (wr_ra) peripheral_routing_a <= sfr_wdata & MASK_ROUTING_A;
            if (wr_rb) peripheral_routing_b <= sfr_wdata & MASK_ROUTING_B;
            if (wr_a0) port0_analog_digital_select <= sfr_wdata;
            if (wr_a1) port1_analog_digital_select <= sfr_wdata;
        end
    end

    // ************************************
    // Read path
    // ************************************
    wire [15:0] latch  = {port1_data_latch, port0_data_latch};
    wire [15:0] dig    = {port1_analog_digital_select, port0_analog_digital_select};
    wire [15:0] pp_sel = {port1_drive_select, port0_drive_select};
    wire [15:0] skip   = {port1_crossbar_bypass, port0_crossbar_bypass};
    // Analog pins read zero; pin level otherwise, peripheral or not
    wire [15:0] pin_view = pin_in & dig;
    // Read-modify-write sees the latch so a bit op cannot copy pin noise
    wire [7:0] rd_p0 = sfr_rmw ? port0_data_latch : pin_view[7:0];
    wire [7:0] rd_p1 = sfr_rmw ? port1_data_latch : pin_view[15:8];

    // Read mux; unmapped addresses answer zero
    logic [7:0] rd_mux;
    always_comb begin
        unique case (sfr_addr)
            ADDR_PORT0_LATCH:  rd_mux = rd_p0;
            ADDR_PORT1_LATCH:  rd_mux = rd_p1;
            ADDR_PORT0_DRIVE:  rd_mux = port0_drive_select;
            ADDR_PORT1_DRIVE:  rd_mux = port1_drive_select;
            ADDR_PORT0_BYPASS: rd_mux = port0_crossbar_bypass;
            ADDR_PORT1_BYPASS: rd_mux = port1_crossbar_bypass;
            ADDR_ROUTING_A:    rd_mux = peripheral_routing_a;
            ADDR_ROUTING_B:    rd_mux = peripheral_routing_b;
            ADDR_PORT0_ANADIG: rd_mux = port0_analog_digital_select;
            ADDR_PORT1_ANADIG: rd_mux = port1_analog_digital_select;
            default:           rd_mux = RST_ZERO;
        endcase
    end

    // Read data flop, held between reads
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            sfr_rdata <= RST_ZERO;
        end else if (sfr_rd) begin
            sfr_rdata <= rd_mux;
        end
    end

    // ************************************
    // Routing requests
    // ************************************
    wire       crossbar_enable = peripheral_routing_b[RB_XBAR];
    wire       pullup_disable  = peripheral_routing_b[RB_PUD];
    wire       uart_route_en   = peripheral_routing_a[RA_UART];
    wire       spi_route_en    = peripheral_routing_a[RA_SPI];
    wire       smbus_route_en  = peripheral_routing_a[RA_SMB];
    wire [1:0] array_module_route_sel = peripheral_routing_b[RB_ARRM+:2];
    wire       uart_on = crossbar_enable & uart_route_en;

    // Request vector, all gated by the crossbar enable
    wire [14:0] raw_req;
    assign raw_req[SG_SCK]  = spi_route_en;
    assign raw_req[SG_MISO] = spi_route_en;
    assign raw_req[SG_MOSI] = spi_route_en;
    assign raw_req[SG_SSEL] = spi_route_en & spi_four_wire;
    assign raw_req[SG_SDA]  = smbus_route_en;
    assign raw_req[SG_SCL]  = smbus_route_en;
    assign raw_req[SG_CMPS] = peripheral_routing_a[RA_CMPS];
    assign raw_req[SG_CMPA] = peripheral_routing_a[RA_CMPA];
    assign raw_req[SG_SYSC] = peripheral_routing_a[RA_SYSC];
    assign raw_req[SG_ARR0] = array_module_route_sel != 2'b00;
    assign raw_req[SG_ARR1] = array_module_route_sel[1];
    assign raw_req[SG_ARR2] = array_module_route_sel == 2'b11;
    assign raw_req[SG_CNT]  = peripheral_routing_b[RB_CNT];
    assign raw_req[SG_TMR0] = peripheral_routing_b[RB_TMR0];
    assign raw_req[SG_TMR1] = peripheral_routing_b[RB_TMR1];
    wire [14:0] sig_req = crossbar_enable ? raw_req : 15'h0000;

    // ************************************
    // Priority decoder
    // ************************************
    logic [15:0] pin_hit;
    logic [3:0]  pin_sig [NPIN];
    logic [14:0] sig_hit;
    logic [3:0]  sig_pin [NSIG];

    // Walk the priority list; each request takes the lowest free pin.
    // Skipped pins and the fixed UART pins count as already taken.
    always_comb begin
        logic [15:0] taken;
        logic        found;
        logic [3:0]  sidx;
        taken = skip | (uart_on ? UART_PIN_MASK : 16'h0000);
        found = 1'b0;
        sidx  = 4'h0;
        pin_hit = 16'h0000;
        sig_hit = 15'h0000;
        for (int p = 0; p < NPIN; p++) pin_sig[p] = 4'h0;
        for (int s = 0; s < NSIG; s++) sig_pin[s] = 4'h0;
        for (int k = 0; k < NSIG; k++) begin
            sidx  = PRIO[4*k +: 4];
            found = 1'b0;
            if (sig_req[sidx]) begin
                for (int p = 0; p < NPIN; p++) begin
                    if (!found && !taken[p]) begin
                        found         = 1'b1;
                        taken[p]      = 1'b1;
                        pin_hit[p]    = 1'b1;
                        pin_sig[p]    = sidx;
                        sig_hit[sidx] = 1'b1;
                        sig_pin[sidx] = p[3:0];
                    end
                end
            end
        end
    end

    // ************************************
    // Pin cells
    // ************************************
    // Cell outputs gathered on nets; a port variable must not have 16 drivers
    wire [15:0] cell_out;
    wire [15:0] cell_oe;
    wire [15:0] cell_pu;
    wire [15:0] smb_pin;
    // Unassigned pins are GPIO; latch always drives, open-drain floats a one
    for (genvar p = 0; p < NPIN; p++) begin : g_pin
        wire is_tx  = uart_on && (p == UART_TX_PIN);
        wire is_rx  = uart_on && (p == UART_RX_PIN);
        wire is_smb = pin_hit[p] && (pin_sig[p] == SG_SDA[3:0]
                                  || pin_sig[p] == SG_SCL[3:0]);
        assign smb_pin[p] = is_smb;
        wire val = is_tx ? uart_transmit_out
                 : pin_hit[p] ? periph_out[pin_sig[p]] : latch[p];
        wire req = is_rx ? 1'b0
                 : (pin_hit[p] && !is_tx) ? periph_oe[pin_sig[p]] : 1'b1;
        pcg_pin_cell u_cell (
            .core_clk   (core_clk),
            .rst        (rst),
            .xbar_en    (crossbar_enable),
            .digital    (dig[p]),
            .push_pull  (pp_sel[p]),
            .force_od   (is_smb),
            .drive_req  (req),
            .value      (val),
            .pud        (pullup_disable),
            .pin_out    (cell_out[p]),
            .pin_oe     (cell_oe[p]),
            .pin_pullup (cell_pu[p])
        );
    end
    // Ports still come straight from the cell flops
    assign pin_out    = cell_out;
    assign pin_oe     = cell_oe;
    assign pin_pullup = cell_pu;

    // ************************************
    // Inputs back to peripherals
    // ************************************
    // Unrouted inputs idle high so a peripheral sees a quiet line
    logic [14:0] next_periph_in;
    always_comb begin
        for (int s = 0; s < NSIG; s++) begin
            next_periph_in[s] = sig_hit[s] ? pin_view[sig_pin[s]] : 1'b1;
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            periph_in       <= 15'h7FFF;
            uart_receive_in <= 1'b1;
        end else begin
            periph_in       <= next_periph_in;
            uart_receive_in <= uart_on ? pin_view[UART_RX_PIN] : 1'b1;
        end
    end

    // ************************************
    // Assertions
    // ************************************
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);

    // Either input-mode register written
    sequence s_write_anadig;
        sfr_wr && (sfr_addr == ADDR_PORT0_ANADIG || sfr_addr == ADDR_PORT1_ANADIG);
    endsequence

    AST_UNUSED_ZERO: assert property (
        (peripheral_routing_a[7:6] == 2'b00) && !peripheral_routing_b[2])
        else $error("Unused routing bits not zero");
    AST_XBAR_OFF_NO_DRIVE: assert property (
        !crossbar_enable |=> pin_oe == 16'h0000)
        else $error("Driver on with crossbar disabled");
    AST_XBAR_OFF_NO_ROUTE: assert property (
        !crossbar_enable |-> sig_hit == 15'h0000 && pin_hit == 16'h0000)
        else $error("Routing active with crossbar disabled");
    AST_CMPA_GATE: assert property (
        sig_hit[SG_CMPA] |-> peripheral_routing_a[RA_CMPA])
        else $error("Async comparator routed while disabled");
    AST_SKIP_HONOURED: assert property (
        (skip & pin_hit) == 16'h0000)
        else $error("Skipped pin assigned");
    AST_ARRAY_COUNT: assert property (
        crossbar_enable && array_module_route_sel == 2'b01
        |-> !sig_req[SG_ARR1] && !sig_req[SG_ARR2] && sig_req[SG_ARR0])
        else $error("Array module field decode wrong");
    AST_LATCH_WRITE: assert property (
        sfr_wr && sfr_addr == ADDR_PORT0_LATCH
        |=> port0_data_latch == $past(sfr_wdata))
        else $error("Port latch not written");
    AST_RMW_READS_LATCH: assert property (
        sfr_rd && sfr_rmw && sfr_addr == ADDR_PORT1_LATCH && !sfr_wr
        |=> sfr_rdata == $past(port1_data_latch))
        else $error("RMW read did not return latch");
    AST_ANALOG_READS_ZERO: assert property (
        sfr_rd && !sfr_rmw && sfr_addr == ADDR_PORT0_LATCH
        |=> (sfr_rdata & ~$past(port0_analog_digital_select)) == 8'h00)
        else $error("Analog pin read nonzero");
    AST_ANALOG_QUIET: assert property (
        s_write_anadig ##1 1'b1
        |=> ((pin_oe | pin_pullup) & ~$past(dig)) == 16'h0000)
        else $error("Analog pin driven or pulled up");
    AST_OD_LOW_ONLY: assert property (
        crossbar_enable && pp_sel == 16'h0000
        |=> (pin_oe & pin_out) == 16'h0000)
        else $error("Open-drain pin drove high");
    AST_PULLUP_NOT_LOW: assert property (
        (pin_pullup & pin_oe & ~pin_out) == 16'h0000)
        else $error("Pullup on while driving low");
    AST_PUD_OFF: assert property (
        pullup_disable |=> pin_pullup == 16'h0000)
        else $error("Pullup on while disabled");
    AST_UART_TX_PIN: assert property (
        uart_on |=> pin_out[UART_TX_PIN] == $past(uart_transmit_out))
        else $error("UART transmit not on its fixed pin");
    AST_CMPS_GATE: assert property (
        !peripheral_routing_a[RA_CMPS] |-> !sig_hit[SG_CMPS])
        else $error("Clocked comparator routed while disabled");
    AST_SYSC_GATE: assert property (
        !peripheral_routing_a[RA_SYSC] |-> !sig_hit[SG_SYSC])
        else $error("System clock routed while disabled");
    AST_SMB_GATE: assert property (
        !smbus_route_en |-> !sig_hit[SG_SDA] && !sig_hit[SG_SCL])
        else $error("SMBus routed while disabled");
    // With seven port 1 pins free both SMBus lines always find a pin
    AST_SMB_BOTH: assert property (
        crossbar_enable && smbus_route_en && skip[15:9] == 7'h00
        |-> sig_hit[SG_SDA] && sig_hit[SG_SCL])
        else $error("SMBus pair not routed together");
    AST_SPI_PINS: assert property (
        crossbar_enable && spi_route_en && skip[15:9] == 7'h00
        |-> $countones(sig_hit[SG_SSEL:SG_SCK]) == (spi_four_wire ? 4 : 3))
        else $error("SPI pin count wrong");
    AST_ECI_GATE: assert property (
        !peripheral_routing_b[RB_CNT] |-> !sig_hit[SG_CNT])
        else $error("Count input routed while disabled");
    AST_TMR_IDLE: assert property (
        !peripheral_routing_b[RB_TMR0] && !peripheral_routing_b[RB_TMR1]
        |=> periph_in[SG_TMR0] && periph_in[SG_TMR1])
        else $error("Unrouted timer input not idle");
    AST_SMB_OPEN_DRAIN: assert property (
        smb_pin != 16'h0000
        |=> (pin_oe & pin_out & $past(smb_pin)) == 16'h0000)
        else $error("SMBus pin drove high");
    AST_PORT_READ_PIN: assert property (
        sfr_rd && !sfr_rmw && sfr_addr == ADDR_PORT1_LATCH
        |=> sfr_rdata == $past(pin_in[15:8] & port1_analog_digital_select))
        else $error("Plain port read did not return pin level");
endmodule // pcg_crossbar
`default_nettype wire

// ==== testbench/pcg_pin_env.sv ====
`timescale 1ns/1ps
`default_nettype none
// ************************************
// Board circuitry on the port pins
// ************************************
module pcg_pin_env (
    input  wire logic        core_clk,   // Core clock
    input  wire logic [15:0] pin_out,    // Device level
    input  wire logic [15:0] pin_oe,     // Device drives
    input  wire logic [15:0] pin_pullup, // Weak pullup on
    input  wire logic [15:0] ext_val,    // Board level
    input  wire logic [15:0] ext_en,     // Board drives
    output logic      [15:0] pin_in      // Wire level
);
    logic [15:0] drift = 16'h0000;
    // Undriven wire flips each cycle so a stale level never passes for a drive
    always_ff @(posedge core_clk) begin
        drift <= ~drift;
    end
    // Device driver first, then board, then pullup
    assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_en & ext_val)
        | (~pin_oe & ~ext_en & (pin_pullup | drift));
endmodule // pcg_pin_env
`default_nettype wire

// ==== testbench/port_crossbar_gpio_tb.sv ====
`timescale 1ns/1ps
`default_nettype none
// ************************************
// Crossbar and port bench
// ************************************
module port_crossbar_gpio_tb;
    logic        core_clk = 1'b0;
    logic        rst = 1'b1;
    logic [7:0]  sfr_addr = 8'h00;
    logic [7:0]  sfr_wdata = 8'h00;
    logic        sfr_wr = 1'b0;
    logic        sfr_rd = 1'b0;
    logic        sfr_rmw = 1'b0;
    logic [14:0] periph_out = 15'h0000;
    logic [14:0] periph_oe = 15'h0000;
    logic        spi_four_wire = 1'b0;
    logic        uart_tx = 1'b0;
    logic [15:0] ext_val = 16'h0000;
    logic [15:0] ext_en = 16'h0000;
    logic [7:0]  sfr_rdata;
    logic [15:0] pin_in, pin_out, pin_oe, pin_pullup;
    logic [14:0] periph_in;
    logic        uart_rx;
    int          bad_count = 0;
    int          cmp_count = 0;
    // Address, write data, expected readback
    logic [23:0] rows [9] = '{24'hE1_FF3F, 24'hE2_0400, 24'hD5_FF7F, 24'hA4_A5A5,
        24'hA5_5A5A, 24'hD4_C3C3, 24'hF2_0F0F, 24'h90_3C3C, 24'h33_FF00};
    pcg_crossbar dut (.core_clk(core_clk), .rst(rst), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr),
        .sfr_wdata(sfr_wdata), .sfr_rd(sfr_rd), .sfr_rmw(sfr_rmw), .sfr_rdata(sfr_rdata),
        .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe), .pin_pullup(pin_pullup),
        .periph_out(periph_out), .periph_oe(periph_oe), .periph_in(periph_in),
        .spi_four_wire(spi_four_wire), .uart_transmit_out(uart_tx), .uart_receive_in(uart_rx));
    pcg_pin_env env (.core_clk(core_clk), .pin_out(pin_out), .pin_oe(pin_oe),
        .pin_pullup(pin_pullup), .ext_val(ext_val), .ext_en(ext_en), .pin_in(pin_in));
    initial begin
        forever #20 core_clk = ~core_clk;
    end
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            bad_count++;
            $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    // Strobe held across one rising edge, dropped at the next falling one
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge core_clk);
        {sfr_addr, sfr_wdata, sfr_wr} = {a, d, 1'b1};
        @(negedge core_clk);
        sfr_wr = 1'b0;
    endtask
    task automatic rdc(input logic [7:0] a, input logic m, input logic [7:0] exp);
        @(negedge core_clk);
        {sfr_addr, sfr_rmw, sfr_rd} = {a, m, 1'b1};
        @(negedge core_clk);
        sfr_rd = 1'b0;
        @(negedge core_clk);
        chk({8'h00, sfr_rdata}, {8'h00, exp});
    endtask
    // Pins lag their cause by a register stage
    task automatic st;
        repeat (3) @(negedge core_clk);
    endtask
    task automatic do_reset;
        rst = 1'b1;
        repeat (6) @(negedge core_clk);
        chk(pin_oe, 16'h0000);
        rst = 1'b0;
    endtask
    task automatic test_done;
        $display("compares %0d mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    initial begin
        #400000;
        bad_count++;
        test_done();
    end
    initial begin
        do_reset();
        for (int i = 0; i < 9; i++) begin
            wr(rows[i][23:16], rows[i][15:8]);
            rdc(rows[i][23:16], rows[i][23:21] == 3'b100, rows[i][7:0]);
        end
        // Second reset must undo the writes above; routing A, port 1 skip and port 1 latch are checked
        do_reset();
        rdc(8'hE1, 1'b0, 8'h00);
        rdc(8'hD5, 1'b0, 8'h00);
        rdc(8'h90, 1'b1, 8'hFF);
        $display("register test done");
        wr(8'h80, 8'h00);
        st();
        chk(pin_oe, 16'h0000);
        wr(8'hE2, 8'h40);
        st();
        chk(pin_oe, 16'h00FF);
        chk(pin_pullup, 16'hFF00);
        wr(8'hE2, 8'hC0);
        wr(8'hA5, 8'hFF);
        wr(8'hF2, 8'hFE);
        st();
        chk(pin_pullup, 16'h0000);
        chk(pin_oe, 16'hFEFF);
        chk(pin_out & pin_oe, 16'hFE00);
        wr(8'hA5, 8'h00);
        wr(8'hD5, 8'h01);
        {ext_en, ext_val} = {16'hFF00, 16'hA500};
        st();
        rdc(8'h90, 1'b0, 8'hA4);
        rdc(8'h90, 1'b1, 8'hFF);
        $display("pin mode test done");
        wr(8'h80, 8'hFF);
        wr(8'hD4, 8'h03);
        periph_oe = 15'h0005;
        wr(8'hE1, 8'h03);
        st();
        chk(pin_oe, 16'h0054);
        {spi_four_wire, uart_tx, periph_oe, ext_en} = {1'b1, 1'b1, 15'h000D, 16'h0020};
        st();
        chk(pin_oe, 16'h00C4);
        chk({15'h0000, uart_rx}, 16'h0000);
        wr(8'hE1, 8'h04);
        wr(8'hD4, 8'h00);
        wr(8'hA4, 8'hFF);
        {periph_oe, periph_out} = {15'h0030, 15'h0030};
        st();
        chk(pin_oe, 16'h00FC);
        wr(8'hE1, 8'h00);
        wr(8'hA4, 8'h00);
        {ext_en, periph_oe, periph_out} = {16'h0001, 15'h0E00, 15'h0000};
        for (int k = 0; k < 4; k++) begin
            wr(8'hE2, 8'hC0 | 8'(k));
            st();
            chk(pin_oe, (16'h0001 << k) - 16'h0001);
        end
        wr(8'hE2, 8'hD0);
        st();
        chk({15'h0000, periph_in[13]}, 16'h0000);
        // Comparators, clock out and count input take pins 0 to 3 in order
        wr(8'hE2, 8'hC8);
        wr(8'hE1, 8'h38);
        {ext_en, periph_oe} = {16'h0008, 15'h01C0};
        st();
        chk(pin_oe, 16'h0007);
        chk({15'h0000, periph_in[12]}, 16'h0000);
        $display("routing test done");
        test_done();
    end
endmodule // port_crossbar_gpio_tb
`default_nettype wire
